/* File: logic/nci_host.sv */
// Purpose: host sequencer that drives a NAND card over its pins
// Assumes: card pins asynchronous to i_clock; ready/busy high = ready
// Notes:   one operation at a time; bytes pass one by one, no buffer
`timescale 1ns/10ps
module nci_host
    import nci_pkg::*;
(
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    input  wire logic        i_start,
    input  wire logic [1:0]  i_op,
    input  wire logic [31:0] i_addr,
    input  wire logic [7:0]  i_wdata,
    output logic             o_wready,
    output logic [7:0]       o_rdata,
    output logic             o_rvalid,
    output logic             o_busy,
    output logic             o_timeout,
    output logic             o_cmd_latch,
    output logic             o_addr_latch,
    output logic             o_chip_enable_n,
    output logic             o_write_strobe_n,
    output logic             o_read_strobe_n,
    output logic [7:0]       o_bus_out,
    output logic             o_bus_oe,
    input  wire logic [7:0]  i_bus_in,
    input  wire logic        i_ready_busy
);
    nci_strobe_if  sif ();
    nci_state_type st_q;
    nci_state_type st_d;
    nci_op_type    op_q;
    nci_op_type    op_d;
    logic [31:0]   addr_q;
    logic [31:0]   addr_d;
    logic [2:0]    acnt_q;
    logic [2:0]    acnt_d;
    logic [9:0]    bcnt_q;
    logic [9:0]    bcnt_d;
    logic [12:0]   wcnt_q;
    logic [12:0]   wcnt_d;
    logic [7:0]    out_q;
    logic [7:0]    out_d;
    logic [7:0]    rdata_q;
    logic [7:0]    rdata_d;
    logic          rvalid_q;
    logic          rvalid_d;
    logic          tout_q;
    logic          tout_d;
    logic          issued_q;
    logic          issued_d;
    logic          sel_n;

    nci_strobe_gen u_strobe
    (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .s       (sif)
    );

    always_comb
    begin
        st_d     = st_q;
        op_d     = op_q;
        addr_d   = addr_q;
        acnt_d   = acnt_q;
        bcnt_d   = bcnt_q;
        wcnt_d   = wcnt_q;
        out_d    = out_q;
        rdata_d  = rdata_q;
        rvalid_d = 1'b0;
        tout_d   = tout_q;
        issued_d = issued_q;
        sif.go   = 1'b0;
        sif.rd   = 1'b0;
        case (st_q)
            ST_IDLE:
            begin
                if (i_start)
                begin
                    op_d   = nci_op_type'(i_op);
                    addr_d = i_addr;
                    tout_d = 1'b0;
                    st_d   = ST_CMD;
                    issued_d = 1'b0;
                    case (nci_op_type'(i_op))
                        OP_PROG:  out_d = CMD_SEQ_IN;
                        OP_ID:    out_d = CMD_READ_ID;
                        OP_RESET: out_d = CMD_RESET;
                        default:  out_d = CMD_READ;
                    endcase
                end
            end
            ST_CMD, ST_CMD2:
            begin
                sif.go   = !issued_q;
                issued_d = 1'b1;
                if (sif.done)
                begin
                    issued_d = 1'b0;
                    wcnt_d   = 13'h0000;
                    if (st_q == ST_CMD2 || op_q == OP_RESET)
                        st_d = ST_BUSY;
                    else
                    begin
                        st_d   = ST_ADDR;
                        acnt_d = (op_q == OP_ID) ? ADDR_BYTES_ID
                                                 : ADDR_BYTES_PAGE;
                        out_d  = (op_q == OP_ID) ? 8'h00 : addr_q[7:0];
                    end
                end
            end
            ST_ADDR:
            begin
                sif.go   = !issued_q;
                issued_d = 1'b1;
                if (sif.done)
                begin
                    issued_d = 1'b0;
                    addr_d   = {8'h00, addr_q[31:8]};
                    acnt_d   = acnt_q - 3'h1;
                    out_d    = addr_q[15:8];
                    wcnt_d   = 13'h0000;
                    if (acnt_q == 3'h1)
                    begin
                        case (op_q)
                            OP_PROG:
                            begin
                                st_d   = ST_WDATA;
                                bcnt_d = PROG_BYTES;
                            end
                            OP_ID:
                            begin
                                st_d   = ST_RDATA;
                                bcnt_d = ID_BYTES;
                            end
                            default:
                            begin
                                st_d   = ST_SETTLE;
                                bcnt_d = READ_BYTES;
                            end
                        endcase
                    end
                end
            end
            ST_SETTLE:
            begin
                // give the card time to pull busy low before we trust it
                wcnt_d = wcnt_q + 13'h0001;
                if (wcnt_q == 13'(SETTLE_CYC))
                begin
                    st_d   = ST_WAIT;
                    wcnt_d = 13'h0000;
                end
            end
            ST_WAIT, ST_BUSY:
            begin
                wcnt_d = wcnt_q + 13'h0001;
                if (i_ready_busy)
                    st_d = (st_q == ST_WAIT) ? ST_RDATA : ST_IDLE;
                else if (wcnt_q == 13'(BUSY_WAIT_CYC))
                begin
                    tout_d = 1'b1;
                    st_d   = ST_IDLE;
                end
            end
            ST_WDATA:
            begin
                sif.go   = !issued_q && !issued_d;
                if (!issued_q)
                begin
                    out_d    = i_wdata;
                    sif.go   = 1'b1;
                    issued_d = 1'b1;
                end
                if (sif.done)
                begin
                    issued_d = 1'b0;
                    bcnt_d   = bcnt_q - 10'h001;
                    if (bcnt_q == 10'h001)
                    begin
                        st_d  = ST_CMD2;
                        out_d = CMD_PROG;
                    end
                end
            end
            ST_RDATA:
            begin
                sif.rd   = 1'b1;
                sif.go   = !issued_q;
                issued_d = 1'b1;
                // take the byte while the strobe is low: the card
                // floats the bus soon after the strobe rises
                if (!sif.strobe_n)
                    rdata_d = i_bus_in;
                if (sif.done)
                begin
                    issued_d = 1'b0;
                    rvalid_d = 1'b1;
                    bcnt_d   = bcnt_q - 10'h001;
                    wcnt_d   = 13'h0000;
                    if (bcnt_q == 10'h001)
                        st_d = ST_BREAK;
                end
            end
            ST_BREAK:
            begin
                wcnt_d = wcnt_q + 13'h0001;
                if (wcnt_q == 13'(BREAK_CYC))
                    st_d = ST_IDLE;
            end
            default: st_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            st_q     <= ST_IDLE;
            op_q     <= OP_READ;
            addr_q   <= 32'h00000000;
            acnt_q   <= 3'h0;
            bcnt_q   <= 10'h000;
            wcnt_q   <= 13'h0000;
            out_q    <= 8'h00;
            rdata_q  <= 8'h00;
            rvalid_q <= 1'b0;
            tout_q   <= 1'b0;
            issued_q <= 1'b0;
        end
        else
        begin
            st_q     <= st_d;
            op_q     <= op_d;
            addr_q   <= addr_d;
            acnt_q   <= acnt_d;
            bcnt_q   <= bcnt_d;
            wcnt_q   <= wcnt_d;
            out_q    <= out_d;
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
            tout_q   <= tout_d;
            issued_q <= issued_d;
        end
    end

    // own select high only in idle and break; card busy pulls enable low
    assign sel_n            = (st_q == ST_IDLE) || (st_q == ST_BREAK);
    assign o_chip_enable_n  = sel_n & i_ready_busy;
    assign o_cmd_latch      = (st_q == ST_CMD) ||
                              (st_q == ST_CMD2);
    assign o_addr_latch     = st_q == ST_ADDR;
    assign o_write_strobe_n = sif.rd | sif.strobe_n;
    assign o_read_strobe_n  = !sif.rd | sif.strobe_n;
    assign o_bus_out        = out_q;
    assign o_bus_oe         = (st_q == ST_CMD) || (st_q == ST_CMD2) ||
                              (st_q == ST_ADDR) || (st_q == ST_WDATA);
    assign o_wready         = (st_q == ST_WDATA) && !issued_q;
    assign o_rdata          = rdata_q;
    assign o_rvalid         = rvalid_q;
    assign o_busy           = st_q != ST_IDLE;
    assign o_timeout        = tout_q;

    property p_no_read_while_busy;
        @(posedge i_clock) disable iff (i_rst)
        !o_read_strobe_n |-> i_ready_busy;
    endproperty
    a_no_read_while_busy: assert property (p_no_read_while_busy)
        else $error("read strobe while card busy");

    property p_ce_low_loading;
        @(posedge i_clock) disable iff (i_rst)
        !i_ready_busy |-> !o_chip_enable_n;
    endproperty
    a_ce_low_loading: assert property (p_ce_low_loading)
        else $error("chip enable high during page load");

    property p_latch_exclusive;
        @(posedge i_clock) disable iff (i_rst)
        !(o_cmd_latch && o_addr_latch);
    endproperty
    a_latch_exclusive: assert property (p_latch_exclusive)
        else $error("both latch selects high");

    property p_addr_needs_drive;
        @(posedge i_clock) disable iff (i_rst)
        !o_write_strobe_n |-> o_bus_oe;
    endproperty
    a_addr_needs_drive: assert property (p_addr_needs_drive)
        else $error("write strobe without bus drive");

    property p_read_undriven;
        @(posedge i_clock) disable iff (i_rst)
        !o_read_strobe_n |-> !o_bus_oe && !o_cmd_latch && !o_addr_latch;
    endproperty
    a_read_undriven: assert property (p_read_undriven)
        else $error("bus driven during read strobe");

    property p_break_hold;
        @(posedge i_clock) disable iff (i_rst)
        (st_q == ST_RDATA && st_d == ST_BREAK) |=>
            (o_chip_enable_n || !i_ready_busy)[*2];
    endproperty
    a_break_hold: assert property (p_break_hold)
        else $error("select not held high after last read");

    property p_read_byte_count;
        @(posedge i_clock) disable iff (i_rst)
        (st_q == ST_ADDR && st_d == ST_SETTLE) |=> bcnt_q == READ_BYTES;
    endproperty
    a_read_byte_count: assert property (p_read_byte_count)
        else $error("page read count wrong");

    property p_strobe_to_data;
        @(posedge i_clock) disable iff (i_rst)
        $rose(o_read_strobe_n) |=> o_rvalid;
    endproperty
    a_strobe_to_data: assert property (p_strobe_to_data)
        else $error("read byte not presented");

    c_read: cover property (@(posedge i_clock) st_q == ST_BREAK);
    c_prog: cover property (@(posedge i_clock) st_q == ST_CMD2);
    c_reset: cover property
        (@(posedge i_clock) st_q == ST_BUSY && op_q == OP_RESET);
    c_tout: cover property (@(posedge i_clock) $rose(o_timeout));
endmodule

/* File: logic/nci_pkg.sv */
// Purpose: constants and types shared by the card host controller
// Assumes: 10 MHz clock, 100 ns period
// Notes:   card pins are asynchronous to us; we pace every edge by cycles
// How it works
// - host raises command latch select only for command bytes
// - host raises address latch select only during address bytes
// - host holds chip enable high over 100 ns to end sequential read
// - host keeps chip enable low while card loads a page
// - chip enable is own select ANDed with ready/busy
// - host programs 512 data bytes, reads back 528 bytes
package nci_pkg;
    localparam int unsigned CLOCK_NS        = 100;
    localparam int unsigned PAGE_LOAD_US    = 12;
    localparam int unsigned RESET_MAX_US    = 500;
    localparam int unsigned BREAK_HOLD_NS   = 100;
    localparam int unsigned LAST_TO_BUSY_NS = 100;
    // longest waits round down, least times round up
    localparam int unsigned BUSY_WAIT_CYC   =
        (RESET_MAX_US * 1000) / CLOCK_NS;
    localparam int unsigned BREAK_CYC       =
        (BREAK_HOLD_NS + CLOCK_NS - 1) / CLOCK_NS + 1;
    localparam int unsigned SETTLE_CYC      =
        (LAST_TO_BUSY_NS + CLOCK_NS - 1) / CLOCK_NS + 1;
    localparam logic [9:0]  PROG_BYTES      = 10'h200;
    localparam logic [9:0]  READ_BYTES      = 10'h210;
    localparam logic [9:0]  ID_BYTES        = 10'h002;
    localparam logic [7:0]  CMD_READ        = 8'h00;
    localparam logic [7:0]  CMD_SEQ_IN      = 8'h80;
    localparam logic [7:0]  CMD_PROG        = 8'h10;
    localparam logic [7:0]  CMD_READ_ID     = 8'h90;
    localparam logic [7:0]  CMD_RESET       = 8'hff;
    localparam logic [2:0]  ADDR_BYTES_PAGE = 3'h4;
    localparam logic [2:0]  ADDR_BYTES_ID   = 3'h1;

    typedef enum logic [1:0]
    {
        OP_READ  = 2'b00,
        OP_PROG  = 2'b01,
        OP_ID    = 2'b10,
        OP_RESET = 2'b11
    } nci_op_type;

    typedef enum logic [3:0]
    {
        ST_IDLE   = 4'b0000,
        ST_CMD    = 4'b0001,
        ST_ADDR   = 4'b0010,
        ST_WAIT   = 4'b0011,
        ST_RDATA  = 4'b0100,
        ST_WDATA  = 4'b0101,
        ST_CMD2   = 4'b0110,
        ST_BUSY   = 4'b0111,
        ST_BREAK  = 4'b1000,
        ST_SETTLE = 4'b1001
    } nci_state_type;

    typedef enum logic [1:0]
    {
        PH_SETUP = 2'b00,
        PH_LOW   = 2'b01,
        PH_HIGH  = 2'b10
    } nci_phase_type;
endpackage

/* File: logic/nci_strobe_gen.sv */
// Purpose: one write or read strobe pulse per request
// Assumes: 100 ns clock gives 100 ns setup, low and high phases
// Notes:   every phase one cycle plus an idle request cycle, so cycle time 400 ns meets the card
`timescale 1ns/10ps
module nci_strobe_gen
    import nci_pkg::*;
(
    input  wire logic i_clock,
    input  wire logic i_rst,
    nci_strobe_if.gen s
);
    nci_phase_type ph_q;
    nci_phase_type ph_d;
    logic          busy_q;
    logic          busy_d;

    always_comb
    begin
        ph_d   = ph_q;
        busy_d = busy_q;
        if (!busy_q && s.go)
        begin
            busy_d = 1'b1;
            ph_d   = PH_SETUP;
        end
        else if (busy_q)
        begin
            case (ph_q)
                PH_SETUP: ph_d = PH_LOW;
                PH_LOW:   ph_d = PH_HIGH;
                PH_HIGH:  busy_d = 1'b0;
                default:  busy_d = 1'b0;
            endcase
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            ph_q   <= PH_SETUP;
            busy_q <= 1'b0;
        end
        else
        begin
            ph_q   <= ph_d;
            busy_q <= busy_d;
        end
    end

    assign s.strobe_n = !(busy_q && ph_q == PH_LOW);
    assign s.done     = busy_q && ph_q == PH_HIGH;

    property p_strobe_one_cycle;
        @(posedge i_clock) disable iff (i_rst)
        $fell(s.strobe_n) |=> s.strobe_n && s.done;
    endproperty
    a_strobe_one_cycle: assert property (p_strobe_one_cycle)
        else $error("strobe low not one cycle");
endmodule

/* File: logic/nci_strobe_if.sv */
// Purpose: link between sequencer and strobe pulse generator
// Assumes: one clock domain
// Notes:   go is a one-cycle request, done a one-cycle answer
`timescale 1ns/10ps
interface nci_strobe_if;
    logic       go;
    logic       rd;
    logic       done;
    logic       strobe_n;
    modport seq
    (
        output go,
        output rd,
        input  done,
        input  strobe_n
    );
    modport gen
    (
        input  go,
        input  rd,
        output done,
        output strobe_n
    );
endinterface

/* File: testbench/nci_card_model.sv */
// Purpose: behavioural card on the far side of the host controller
// Assumes: pins are edge driven by the host; no clock is shared
// Notes:   errs counts host protocol slips seen at the pins
`timescale 1ns/10ps
module nci_card_model
    import nci_pkg::*;
#(
    parameter int         LOAD_NS = 5000,
    parameter int         PROG_NS = 20000,
    parameter int         RST_NS  = 3000,
    parameter int         NEXT_NS = 100,
    parameter logic [7:0] MAKER   = 8'ha5, // arbitrary value
    parameter logic [7:0] DEVICE  = 8'h3c  // arbitrary value
)
(
    input  wire logic       i_cmd_latch,
    input  wire logic       i_addr_latch,
    input  wire logic       i_chip_enable_n,
    input  wire logic       i_write_strobe_n,
    input  wire logic       i_read_strobe_n,
    input  wire logic [7:0] i_bus,
    input  wire logic       i_bus_oe,
    input  wire logic       i_stall,
    output logic      [7:0] o_bus,
    output logic            o_ready_busy
);
    logic [7:0]  page [0:527];
    logic [7:0]  wbuf [0:511];
    logic [7:0]  cmd   = 8'hff;
    logic [7:0]  dout  = 8'h00;
    logic [31:0] addr  = 32'h0000_0000;
    logic        drive = 1'b0;
    logic        rb    = 1'b1;
    int          nadr  = 0;
    int          ptr   = 0;
    int          ncmd  = 0;
    int          errs  = 0;

    initial foreach (page[i]) page[i] = 8'hff;
    assign o_ready_busy = rb;
    // released bus shows the inverse so a late sample cannot pass
    assign o_bus = drive ? dout : ~dout;

    task automatic go_busy(input int ns);
        fork
        begin
            #50 rb = 1'b0;
            #(ns);
            while (i_stall) #100;
            rb = 1'b1;
        end
        join_none
    endtask

    always @(posedge i_write_strobe_n)
    begin
        if (!i_chip_enable_n)
        begin
            if ((i_cmd_latch && i_addr_latch) || i_bus_oe !== 1'b1)
                errs++;
            else if (i_cmd_latch)
            begin
                cmd = i_bus;
                ncmd++;
                nadr = 0;
                ptr = 0;
                if (i_bus == CMD_RESET)
                    go_busy(RST_NS);
                if (i_bus == CMD_PROG)
                begin
                    for (int i = 0; i < 512; i++)
                        page[i] = wbuf[i];
                    go_busy(PROG_NS);
                end
            end
            else if (i_addr_latch)
            begin
                if (nadr < 4)
                    addr[8*nadr+:8] = i_bus;
                nadr++;
                if (cmd == CMD_READ && nadr == 4)
                    go_busy(LOAD_NS);
            end
            else if (ptr < 512)
                wbuf[ptr++] = i_bus;
        end
    end

    always @(negedge i_read_strobe_n)
    begin
        if (!i_chip_enable_n)
        begin
            if (!rb || i_bus_oe !== 1'b0)
                errs++;
            #20;
            dout = (cmd == CMD_READ_ID) ? (ptr == 0 ? MAKER : DEVICE)
                                        : page[ptr % 528];
            drive = 1'b1;
            ptr++;
        end
    end

    always @(posedge i_read_strobe_n)
    begin
        if (!i_chip_enable_n && cmd == CMD_READ && ptr == 528)
        begin
            ptr = 0;
            go_busy(NEXT_NS);
        end
        #30 drive = 1'b0;
    end

    always @(posedge i_chip_enable_n or posedge i_bus_oe)
        drive = 1'b0;
endmodule

/* File: testbench/nci_host_bench.sv */
// Purpose: self-checking bench for the card host controller
// Assumes: card model answers at the pins, shortened busy times
// Notes:   one task per scenario, verdict printed by conclude
`timescale 1ns/10ps
module nci_host_bench;
    import nci_pkg::*;
    localparam logic [7:0]  MAKER = 8'ha5; // arbitrary value
    localparam logic [7:0]  DEVCD = 8'h3c; // arbitrary value
    localparam logic [31:0] PADDR = 32'h0003_0201;
    logic        i_clock = 1'b0;
    logic        i_rst   = 1'b1;
    logic        i_start = 1'b0;
    logic [1:0]  i_op    = 2'b00;
    logic [31:0] i_addr  = 32'h0000_0000;
    logic [7:0]  i_wdata = 8'h5a;
    logic        stall   = 1'b0;
    logic        o_wready, o_rvalid, o_busy, o_timeout, o_bus_oe, rb;
    logic        o_cmd_latch, o_addr_latch, o_chip_enable_n;
    logic        o_write_strobe_n, o_read_strobe_n;
    logic [7:0]  o_rdata, o_bus_out, card_bus;
    wire  [7:0]  bus_wire;
    logic [7:0]  rq [$];
    int          n_errors = 0;
    int          checks   = 0;
    int          wn       = 0;
    int          ce_bad   = 0;
    int          hi_run   = 0;
    int          max_hi   = 0;

    assign bus_wire = o_bus_oe ? o_bus_out : card_bus;
    always #50 i_clock = ~i_clock;

    nci_host nci_host_inst
    (
        .i_clock(i_clock), .i_rst(i_rst), .i_start(i_start), .i_op(i_op),
        .i_addr(i_addr), .i_wdata(i_wdata), .o_wready(o_wready),
        .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_busy(o_busy),
        .o_timeout(o_timeout), .o_cmd_latch(o_cmd_latch),
        .o_addr_latch(o_addr_latch), .o_chip_enable_n(o_chip_enable_n),
        .o_write_strobe_n(o_write_strobe_n),
        .o_read_strobe_n(o_read_strobe_n), .o_bus_out(o_bus_out),
        .o_bus_oe(o_bus_oe), .i_bus_in(bus_wire), .i_ready_busy(rb)
    );

    nci_card_model #(.MAKER(MAKER), .DEVICE(DEVCD)) nci_card_model_inst
    (
        .i_cmd_latch(o_cmd_latch), .i_addr_latch(o_addr_latch),
        .i_chip_enable_n(o_chip_enable_n),
        .i_write_strobe_n(o_write_strobe_n),
        .i_read_strobe_n(o_read_strobe_n), .i_bus(bus_wire),
        .i_bus_oe(o_bus_oe), .i_stall(stall), .o_bus(card_bus),
        .o_ready_busy(rb)
    );

    function automatic logic [7:0] pat(input int k);
        return k[7:0] ^ 8'h5a;
    endfunction

    always @(posedge i_clock)
    begin
        if (o_rvalid === 1'b1)
            rq.push_back(o_rdata);
        if (o_wready === 1'b1)
        begin
            wn++;
            i_wdata <= pat(wn);
        end
        if (o_busy === 1'b1 && rb === 1'b0 && o_chip_enable_n !== 1'b0)
            ce_bad++;
        if (o_busy === 1'b1 && o_chip_enable_n === 1'b1)
            hi_run = hi_run + 1;
        else
            hi_run = 0;
        if (hi_run > max_hi)
            max_hi = hi_run;
    end

    task automatic chk(input logic [31:0] got, exp, input string what);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // returns the number of cycles the operation kept o_busy high
    task automatic run_op(input logic [1:0] op, input logic [31:0] adr,
                          output int cyc);
        rq.delete();
        wn = 0;
        max_hi = 0;
        @(posedge i_clock);
        i_start <= 1'b1;
        i_op    <= op;
        i_addr  <= adr;
        i_wdata <= pat(0);
        @(posedge i_clock);
        i_start <= 1'b0;
        #1;
        chk(o_busy, 1'b1, "start taken");
        for (cyc = 0; cyc < 12000 && o_busy !== 1'b0; cyc++)
        begin
            @(posedge i_clock);
            #1;
        end
        if (cyc == 12000)
        begin
            n_errors++;
            $display("BAD %0t operation never ended", $time);
            conclude();
        end
        repeat (2) @(posedge i_clock);
    endtask

    task automatic t_reset();
        #1;
        chk({o_write_strobe_n, o_read_strobe_n}, 2'b11, "idle strobes");
        chk({o_cmd_latch, o_addr_latch, o_bus_oe}, 3'b000, "idle latches");
        chk({o_busy, o_chip_enable_n}, {1'b0, rb}, "idle busy, enable");
        $display("test reset done");
    endtask

    task automatic t_id();
        int n;
        run_op(OP_ID, 32'h0000_0000, n);
        chk(rq.size(), 2, "id byte count");
        chk(rq[0], MAKER, "first id byte");
        chk(rq[1], DEVCD, "device code");
        chk(nci_card_model_inst.cmd, CMD_READ_ID, "id command");
        chk(nci_card_model_inst.addr[7:0], 8'h00, "id address");
        $display("test id done");
    endtask

    task automatic t_prog_read();
        int n;
        int c0;
        c0 = nci_card_model_inst.ncmd;
        run_op(OP_PROG, PADDR, n);
        chk(wn, 512, "program byte count");
        chk(nci_card_model_inst.addr, PADDR, "program address");
        chk(nci_card_model_inst.ncmd - c0, 2, "program cmds");
        run_op(OP_READ, PADDR, n);
        chk(rq.size(), 528, "read byte count");
        for (int i = 0; i < rq.size(); i++)
            chk(rq[i], i < 512 ? pat(i) : 8'hff, "read data");
        chk(max_hi >= 2, 1'b1, "break enable high");
        chk(ce_bad, 0, "enable during load");
        chk(nci_card_model_inst.errs, 0, "pin protocol");
        $display("test program and read done");
    endtask

    task automatic t_refuse();
        int n;
        int c0;
        c0 = nci_card_model_inst.ncmd;
        fork
            run_op(OP_RESET, 32'h0000_0000, n);
            begin
                repeat (12) @(posedge i_clock);
                i_start <= 1'b1;
                i_op    <= OP_ID;
                @(posedge i_clock);
                i_start <= 1'b0;
            end
        join
        chk(nci_card_model_inst.ncmd - c0, 1, "busy start");
        chk(n >= 30, 1'b1, "reset busy wait");
        $display("test refused start done");
    endtask

    task automatic t_timeout();
        int n;
        stall = 1'b1;
        run_op(OP_RESET, 32'h0000_0000, n);
        chk(o_timeout, 1'b1, "stuck busy flagged");
        stall = 1'b0;
        repeat (3) @(posedge i_clock);
        run_op(OP_ID, 32'h0000_0000, n);
        chk(o_timeout, 1'b0, "flag cleared");
        chk(rq[1], DEVCD, "id after recovery");
        $display("test timeout done");
    endtask

    initial
    begin
        repeat (4) @(posedge i_clock);
        i_rst <= 1'b0;
        @(posedge i_clock);
        t_reset();
        t_id();
        t_prog_read();
        t_refuse();
        t_timeout();
        conclude();
    end
endmodule
